// file: rtl/ddsc_params.svh
// Constants of the dual converter serial control link
`ifndef DDSC_PARAMS_SVH
`define DDSC_PARAMS_SVH
`define DDSC_WORD_BITS   5'h10
`define DDSC_CODE_MSB    15
`define DDSC_CODE_LSB    12
`define DDSC_DATA_MSB    11
`define DDSC_DATA_LSB    2
`define DDSC_ZERO_CODE   10'h000
`define DDSC_ZERO_WORD   16'h0000
`define DDSC_SHIFT_TOP   14
`define DDSC_OP_NOP      4'h0
`define DDSC_OP_LOAD_A   4'h1
`define DDSC_OP_LOAD_B   4'h2
`define DDSC_OP_UPD_WAKE 4'h8
`define DDSC_OP_LDA_UPD  4'h9
`define DDSC_OP_LDB_UPD  4'hA
`define DDSC_OP_WAKE     4'hD
`define DDSC_OP_SLEEP    4'hE
`define DDSC_OP_LDAB_UPD 4'hF
`define DDSC_SCK_HALF    4'h4
`endif

// file: rtl/ddsc_pkg.sv
// Types shared by both ends of the serial control link
package ddsc_pkg;
  typedef logic [9:0]  ddsc_code_t;
  typedef logic [15:0] ddsc_word_t;
  typedef enum logic [1:0] {DDSC_IDLE, DDSC_LOW, DDSC_HIGH, DDSC_DONE} ddsc_host_state_t;
endpackage

// file: rtl/ddsc_link_if.sv
// Three-wire link between host and converter control
`timescale 1ns/1ps
`default_nettype none
interface ddsc_link_if;
  logic chip_select_load_b;
  logic serial_clock;
  logic serial_data;
  modport host   (output chip_select_load_b, output serial_clock, output serial_data);
  modport device (input chip_select_load_b, input serial_clock, input serial_data);
endinterface
`default_nettype wire

// file: rtl/ddsc_sync.sv
// Two-flop synchroniser with edge detect on the second stage
`timescale 1ns/1ps
`default_nettype none
module ddsc_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  input  wire logic async_i,
  output logic      level_o,
  output logic      rise_o
);
  logic meta;
  logic stage;
  logic last;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      meta  <= RESET_LEVEL;
      stage <= RESET_LEVEL;
      last  <= RESET_LEVEL;
    end else begin
      meta  <= async_i;
      stage <= meta;
      last  <= stage;
    end
  end
  assign level_o = stage;
  assign rise_o  = stage & ~last;
endmodule
`default_nettype wire

// file: rtl/ddsc_device.sv
// Converter end: serial capture, control decode, double buffer and sleep
// Function
// - Shift only while strobe is low
// - Strobe rise stops shifting, runs decode
// - Sample data on serial clock rise
// - Word: control, ten-bit code, two pads
// - Host sends MSB first, pads last
// - Host raises strobe after sixteen bits
// - Serial clock low when strobe falls
// - Per channel input and output registers
// - Output registers always update together
// - One code may combine several actions
// - Code 1110 sleeps, keeps registers
// - Sleep ignores code field entirely
// - Wake resumes held output values
// - Codes 0001/0010 load input registers
// - Code 1000 wakes and updates both
// - Output registers clear at reset
// - Output code is unsigned binary
// - Code 0000 does nothing
// - Codes 1001/1010 load, update, wake
// - Code 1101 only wakes
// - Code 1111 loads both, updates, wakes
`timescale 1ns/1ps
`default_nettype none
`include "ddsc_params.svh"
module ddsc_device
  import ddsc_pkg::*;
(
  input  wire logic   clk_sys_i,
  input  wire logic   rst_b_i,
  ddsc_link_if.device link,
  output ddsc_code_t  channel_a_output_o,
  output ddsc_code_t  channel_b_output_o,
  output ddsc_code_t  input_a_o,
  output ddsc_code_t  input_b_o,
  output logic        asleep_o,
  output logic        outputs_enabled_o
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Each pin passes two flops before any logic reads it
  // The strobe idles high, so its synchroniser resets high to avoid a
  // false strobe rise, and a stray decode, straight after reset
  logic cs_level;
  logic cs_rise;
  logic sck_rise;
  logic din_level;

  ddsc_sync #(
    .RESET_LEVEL (1'b1)
  ) u_cs (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .async_i   (link.chip_select_load_b),
    .level_o   (cs_level),
    .rise_o    (cs_rise)
  );

  ddsc_sync #(
    .RESET_LEVEL (1'b0)
  ) u_sck (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .async_i   (link.serial_clock),
    .level_o   (),
    .rise_o    (sck_rise)
  );

  ddsc_sync #(
    .RESET_LEVEL (1'b0)
  ) u_din (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .async_i   (link.serial_data),
    .level_o   (din_level),
    .rise_o    ()
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ddsc_word_t shift;
    ddsc_code_t in_a;
    ddsc_code_t in_b;
    ddsc_code_t out_a;
    ddsc_code_t out_b;
    logic       sleep;
  } ddsc_dev_state_t;
  ddsc_dev_state_t st;
  ddsc_dev_state_t next_st;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // One code may ask for several actions; each is a flag of its own
  logic [3:0] op;
  ddsc_code_t data;
  logic       do_load_a;
  logic       do_load_b;
  logic       do_update;
  logic       do_wake;
  logic       do_sleep;

  always_comb begin
    next_st   = st;
    op        = st.shift[`DDSC_CODE_MSB:`DDSC_CODE_LSB];
    data      = st.shift[`DDSC_DATA_MSB:`DDSC_DATA_LSB];
    do_load_a = 1'b0;
    do_load_b = 1'b0;
    do_update = 1'b0;
    do_wake   = 1'b0;
    do_sleep  = 1'b0;
    case (op)
      `DDSC_OP_LOAD_A: begin
        do_load_a = 1'b1;
      end
      `DDSC_OP_LOAD_B: begin
        do_load_b = 1'b1;
      end
      `DDSC_OP_UPD_WAKE: begin
        do_update = 1'b1;
        do_wake   = 1'b1;
      end
      `DDSC_OP_LDA_UPD: begin
        do_load_a = 1'b1;
        do_update = 1'b1;
        do_wake   = 1'b1;
      end
      `DDSC_OP_LDB_UPD: begin
        do_load_b = 1'b1;
        do_update = 1'b1;
        do_wake   = 1'b1;
      end
      `DDSC_OP_WAKE: begin
        do_wake = 1'b1;
      end
      `DDSC_OP_SLEEP: begin
        do_sleep = 1'b1;
      end
      `DDSC_OP_LDAB_UPD: begin
        do_load_a = 1'b1;
        do_load_b = 1'b1;
        do_update = 1'b1;
        do_wake   = 1'b1;
      end
      default: begin
        do_sleep = 1'b0;
      end
    endcase
    // Data is sampled with the synchronised clock so both stay aligned
    if (!cs_level && sck_rise) begin
      next_st.shift = {st.shift[`DDSC_SHIFT_TOP:0], din_level};
    end
    if (cs_rise) begin
      if (do_load_a) begin
        next_st.in_a = data;
      end
      if (do_load_b) begin
        next_st.in_b = data;
      end
      // Outputs take the freshly loaded codes, and both channels move together
      if (do_update) begin
        next_st.out_a = do_load_a ? data : st.in_a;
        next_st.out_b = do_load_b ? data : st.in_b;
      end
      if (do_wake) begin
        next_st.sleep = 1'b0;
      end
      if (do_sleep) begin
        next_st.sleep = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // A reset in mid-frame drops the partial word; the host must resend it
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st.shift <= `DDSC_ZERO_WORD;
      st.in_a  <= `DDSC_ZERO_CODE;
      st.in_b  <= `DDSC_ZERO_CODE;
      st.out_a <= `DDSC_ZERO_CODE;
      st.out_b <= `DDSC_ZERO_CODE;
      st.sleep <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Codes are unsigned straight binary; the analog stage scales by k/1024
  // Sleep keeps every register; only the analog drive is switched off
  assign channel_a_output_o = st.out_a;
  assign channel_b_output_o = st.out_b;
  assign input_a_o          = st.in_a;
  assign input_b_o          = st.in_b;
  assign asleep_o           = st.sleep;
  assign outputs_enabled_o  = ~st.sleep;
endmodule
`default_nettype wire

// file: rtl/ddsc_host.sv
// Host end: sends one sixteen-bit command word per request
`timescale 1ns/1ps
`default_nettype none
`include "ddsc_params.svh"
module ddsc_host
  import ddsc_pkg::*;
(
  input  wire logic  clk_sys_i,
  input  wire logic  rst_b_i,
  input  wire logic  req_valid_i,
  input  wire logic [3:0] req_code_i,
  input  wire ddsc_code_t req_data_i,
  output logic       req_ready_o,
  output logic       done_o,
  ddsc_link_if.host  link
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ddsc_host_state_t fsm;
    ddsc_word_t       word;
    logic [4:0]       left;
    logic [3:0]       div;
    logic             cs_b;
    logic             sck;
    logic             sdo;
    logic             ready;
    logic             done;
  } ddsc_host_reg_t;
  ddsc_host_reg_t st;
  ddsc_host_reg_t next_st;
  logic tick;

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    tick         = (st.div == `DDSC_SCK_HALF - 4'h1);
    next_st.div  = (st.fsm == DDSC_IDLE || tick) ? 4'h0 : st.div + 4'h1;
    case (st.fsm)
      DDSC_IDLE: begin
        if (req_valid_i && st.ready) begin
          // Control first, then code, MSB first, pads last
          next_st.word  = {req_code_i, req_data_i, 2'b00};
          next_st.left  = `DDSC_WORD_BITS;
          next_st.cs_b  = 1'b0;
          next_st.sck   = 1'b0;
          next_st.sdo   = req_code_i[3];
          next_st.ready = 1'b0;
          next_st.fsm   = DDSC_LOW;
        end else if (!st.ready) begin
          // Ready comes up one cycle after reset leaves
          next_st.ready = 1'b1;
        end
      end
      DDSC_LOW: begin
        if (tick) begin
          next_st.sck  = 1'b1;
          next_st.left = st.left - 5'h01;
          next_st.fsm  = DDSC_HIGH;
        end
      end
      DDSC_HIGH: begin
        if (tick) begin
          next_st.sck  = 1'b0;
          next_st.word = {st.word[14:0], 1'b0};
          next_st.sdo  = st.word[14];
          next_st.fsm  = (st.left == 5'h00) ? DDSC_DONE : DDSC_LOW;
        end
      end
      DDSC_DONE: begin
        // Strobe rises a half period after the last clock fall
        if (tick) begin
          next_st.cs_b  = 1'b1;
          next_st.ready = 1'b1;
          next_st.done  = 1'b1;
          next_st.fsm   = DDSC_IDLE;
        end
      end
      default: next_st.fsm = DDSC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st.fsm   <= DDSC_IDLE;
      st.word  <= 16'h0000;
      st.left  <= 5'h00;
      st.div   <= 4'h0;
      st.cs_b  <= 1'b1;
      st.sck   <= 1'b0;
      st.sdo   <= 1'b0;
      st.ready <= 1'b0;
      st.done  <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign req_ready_o             = st.ready;
  assign done_o                  = st.done;
  assign link.chip_select_load_b = st.cs_b;
  assign link.serial_clock       = st.sck;
  assign link.serial_data        = st.sdo;
endmodule
`default_nettype wire

// file: tb/ddsc_link_props.sv
// Wire-level properties of the host end of the serial link
`timescale 1ns/1ps
`default_nettype none
module ddsc_link_props (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic chip_select_load_b,
  input wire logic serial_clock,
  input wire logic serial_data
);
  // ----------
  // Rise count
  // ----------
  logic [4:0] rises;
  logic       sck_q;
  always_ff @(posedge clk_sys_i) begin
    sck_q <= serial_clock;
    if (!rst_b_i || chip_select_load_b) rises <= 5'h00;
    else if (serial_clock && !sck_q) rises <= rises + 5'h01;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  property p_start; $fell(chip_select_load_b) |-> (!serial_clock) [*4]; endproperty
  property p_idle; chip_select_load_b && $past(chip_select_load_b) |-> !serial_clock; endproperty
  property p_stable; serial_clock |-> $stable(serial_data); endproperty
  property p_high; $rose(serial_clock) |-> serial_clock [*4] ##1 !serial_clock; endproperty
  property p_low; $fell(serial_clock) |-> (!serial_clock) [*4]; endproperty
  property p_count; $rose(chip_select_load_b) |-> rises == 5'h10; endproperty
  property p_pads; $rose(serial_clock) && rises >= 5'h0E |-> !serial_data; endproperty
  property p_frame; $fell(chip_select_load_b) |-> ##[126:140] $rose(chip_select_load_b); endproperty
  a_start: assert property (p_start) else $error("clock high at strobe fall");
  a_idle: assert property (p_idle) else $error("clock moved outside a frame");
  a_stable: assert property (p_stable) else $error("data moved while clock high");
  a_high: assert property (p_high) else $error("clock high time wrong");
  a_low: assert property (p_low) else $error("clock low time wrong");
  a_count: assert property (p_count) else $error("strobe rose before sixteen bits");
  a_pads: assert property (p_pads) else $error("pad bit not zero");
  a_frame: assert property (p_frame) else $error("frame length wrong");
  c_frame: cover property ($rose(chip_select_load_b));
  c_start: cover property ($fell(chip_select_load_b));
  c_full: cover property (rises == 5'h10);
endmodule
`default_nettype wire

// file: tb/dual_dac_serial_control_tb_top.sv
// Bench driving the host end and watching the converter end
`timescale 1ns/1ps
`default_nettype none
module dual_dac_serial_control_tb_top
  import ddsc_pkg::*;
();
  // -----
  // Setup
  // -----
  typedef struct packed {logic [3:0] c; ddsc_code_t d, a, b, ia, ib; logic s;} ddsc_row_t;
  logic       clk_sys_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       req_valid = 1'b0;
  logic [3:0] req_code = 4'h0;
  ddsc_code_t req_data = 10'h000;
  logic       req_ready, done, asleep, enabled;
  ddsc_code_t out_a, out_b, in_a, in_b, out2_a;
  int         failures = 0;
  int         comparisons = 0;
  logic [3:0] rsv [7] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hB, 4'hC};
  ddsc_row_t  rows [12] = '{
    '{4'h1, 10'h3FF, 10'h000, 10'h000, 10'h3FF, 10'h000, 1'h0},
    '{4'hE, 10'h2AA, 10'h000, 10'h000, 10'h3FF, 10'h000, 1'h1},
    '{4'h2, 10'h155, 10'h000, 10'h000, 10'h3FF, 10'h155, 1'h1},
    '{4'h0, 10'h111, 10'h000, 10'h000, 10'h3FF, 10'h155, 1'h1},
    '{4'h8, 10'h0C3, 10'h3FF, 10'h155, 10'h3FF, 10'h155, 1'h0},
    '{4'h1, 10'h0AA, 10'h3FF, 10'h155, 10'h0AA, 10'h155, 1'h0},
    '{4'hE, 10'h000, 10'h3FF, 10'h155, 10'h0AA, 10'h155, 1'h1},
    '{4'hD, 10'h222, 10'h3FF, 10'h155, 10'h0AA, 10'h155, 1'h0},
    '{4'h9, 10'h001, 10'h001, 10'h155, 10'h001, 10'h155, 1'h0},
    '{4'hE, 10'h000, 10'h001, 10'h155, 10'h001, 10'h155, 1'h1},
    '{4'hA, 10'h200, 10'h001, 10'h200, 10'h001, 10'h200, 1'h0},
    '{4'hF, 10'h123, 10'h123, 10'h123, 10'h123, 10'h123, 1'h0}};
  ddsc_link_if link ();
  ddsc_link_if link2 ();
  ddsc_host ddsc_host_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid),
    .req_code_i(req_code), .req_data_i(req_data), .req_ready_o(req_ready), .done_o(done),
    .link(link.host));
  ddsc_device ddsc_device_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .link(link.device),
    .channel_a_output_o(out_a), .channel_b_output_o(out_b), .input_a_o(in_a),
    .input_b_o(in_b), .asleep_o(asleep), .outputs_enabled_o(enabled));
  // Second converter end faces a bench driver that overruns the word length
  ddsc_device ddsc_device_i2 (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .link(link2.device),
    .channel_a_output_o(out2_a), .channel_b_output_o(), .input_a_o(), .input_b_o(),
    .asleep_o(), .outputs_enabled_o());
  ddsc_link_props ddsc_link_props_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .chip_select_load_b(link.chip_select_load_b), .serial_clock(link.serial_clock),
    .serial_data(link.serial_data));
  initial forever #4 clk_sys_i = ~clk_sys_i;
  task automatic stop_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic cmp(input string n, input logic [9:0] e, input logic [9:0] s);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic state(input ddsc_code_t a, b, ia, ib, input logic s);
    cmp("out_a", a, out_a);
    cmp("out_b", b, out_b);
    cmp("in_a", ia, in_a);
    cmp("in_b", ib, in_b);
    cmp("asleep", {9'h000, s}, {9'h000, asleep});
    cmp("enabled", {9'h000, !s}, {9'h000, enabled});
  endtask
  // Holds the request until the edge that sees ready, then waits for done
  task automatic send(input logic [3:0] c, input ddsc_code_t d);
    int i;
    req_valid <= 1'b1;
    req_code <= c;
    req_data <= d;
    for (i = 0; i < 300; i++) begin
      @(posedge clk_sys_i);
      if (req_ready === 1'b1) break;
    end
    req_valid <= 1'b0;
    if (i == 300) begin
      failures++;
      $display("MISMATCH req_ready expected 1 seen %b", req_ready);
      stop_test();
    end
    for (i = 0; i < 300; i++) begin
      @(posedge clk_sys_i);
      if (done === 1'b1) break;
    end
    if (i == 300) begin
      failures++;
      $display("MISMATCH done expected 1 seen %b", done);
      stop_test();
    end
    tick(8);
  endtask
  // Eighteen clock rises in one frame; clock and data stand low between frames
  task automatic raw(input logic [17:0] w);
    link2.chip_select_load_b <= 1'b0;
    for (int i = 17; i >= 0; i--) begin
      link2.serial_data <= w[i];
      tick(4);
      link2.serial_clock <= 1'b1;
      tick(4);
      link2.serial_clock <= 1'b0;
    end
    tick(4);
    link2.chip_select_load_b <= 1'b1;
    link2.serial_data <= 1'b0;
    tick(8);
  endtask
  // ---------
  // Sequence
  // ---------
  initial begin
    link2.chip_select_load_b = 1'b1;
    link2.serial_clock = 1'b0;
    link2.serial_data = 1'b0;
    tick(6);
    rst_b_i <= 1'b1;
    tick(3);
    state(10'h000, 10'h000, 10'h000, 10'h000, 1'b0);
    foreach (rows[i]) begin
      send(rows[i].c, rows[i].d);
      state(rows[i].a, rows[i].b, rows[i].ia, rows[i].ib, rows[i].s);
      $display("row %0d done", i);
    end
    foreach (rsv[i]) begin
      send(rsv[i], 10'h3FF);
      state(10'h123, 10'h123, 10'h123, 10'h123, 1'b0);
    end
    $display("reserved codes done");
    raw({2'b11, 4'hF, 10'h2AA, 2'b11});
    cmp("out2_a", 10'h2AA, out2_a);
    $display("overlong frame done");
    rst_b_i <= 1'b0;
    tick(2);
    rst_b_i <= 1'b1;
    tick(3);
    state(10'h000, 10'h000, 10'h000, 10'h000, 1'b0);
    $display("reset done");
    stop_test();
  end
endmodule
`default_nettype wire
